// file: bus_ctrl_pkg.sv
// Shared types and constants for the instrument bus controller.
// Assumes a 100 MHz clock; all bus lines are active low at the pins.
package bus_ctrl_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_NS = 500;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PPOLL_NS = 2000;
  localparam int unsigned PPOLL_CYC = (PPOLL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IFC_US = 100;
  localparam int unsigned IFC_CYC = IFC_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam logic [7:0] SPOLL_EN = 8'h18;
  localparam logic [7:0] SPOLL_DIS = 8'h19;
  localparam logic [7:0] UNLISTEN = 8'h3F;
  localparam logic [7:0] MY_LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [4:0] MAX_PRIMARY = 5'h1E;

  typedef enum logic [1:0] {
    OP_CMD,
    OP_DATA,
    OP_DATA_END
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] byte_val;
  } word_t;

  // Open-collector bus, pin-level levels: low means asserted
  typedef struct packed {
    logic [7:0] dio_n;
    logic atn_n;
    logic eoi_n;
    logic srq_n;
    logic ifc_n;
    logic ren_n;
    logic dav_n;
    logic nrfd_n;
    logic ndac_n;
  } bus_lines_t;
endpackage : bus_ctrl_pkg

// file: word_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; a stalled consumer keeps every word.
module word_buf #(
  parameter int unsigned WIDTH = 10
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
    logic rd;
    logic wr;
  } state_t;
  state_t st_ff;
  state_t nxt_st;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid_i && (st_ff.cnt != 2'h2);
    pop = out_ready_i && (st_ff.cnt != 2'h0);
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data_i;
      nxt_st.wr = ~st_ff.wr;
    end
    if (pop) begin
      nxt_st.rd = ~st_ff.rd;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready_o = st_ff.cnt != 2'h2;
  assign out_valid_o = st_ff.cnt != 2'h0;
  assign out_data_o = st_ff.mem[st_ff.rd];
endmodule : word_buf

// file: bus_ctrl.sv
// System controller for an instrument bus: commands, data, polls, clear.
// Assumes external open-collector transceivers resolve the pins from enables.
// Summary of operation
// - Eight data lines, first line is LSB
// - End line marks last data byte
// - Each poll responder owns one data line
// - Requester releases service line once polled
// - Nodes go remote only if enabled, listening
// - Remote nodes ignore front panel
// - Ready line free only when all ready
// - Accepted line free only when all accepted
// - Data valid only after settling time (bus_node as talker asserts it one clock after placing its byte)
// - Acceptors may stall start and finish
// - Up to 31 primary, 31 secondary addresses
// - All bus lines active low
// - Service request may come asynchronously
module bus_ctrl #(
  parameter int unsigned IFC_CYCLES = bus_ctrl_pkg::IFC_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  // Outbound words: commands and talker data
  input wire bus_ctrl_pkg::word_t tx_word_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // Inbound data bytes as listener
  output logic [7:0] rx_byte_o,
  output logic rx_end_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic listen_i,
  // Parallel poll request and result
  input wire logic ppoll_req_i,
  output logic [7:0] ppoll_status_o,
  output logic ppoll_done_o,
  // Automatic serial poll on service request
  input wire logic auto_spoll_i,
  input wire logic [4:0] my_addr_i,
  input wire logic [4:0] spoll_addr_i,
  output logic [7:0] spoll_status_o,
  output logic spoll_done_o,
  output logic srq_pending_o,
  // Interface clear and remote enable
  input wire logic ifc_req_i,
  input wire logic remote_en_i,
  output logic in_charge_o,
  // Bus pins: inputs, outputs and output enables
  input wire bus_ctrl_pkg::bus_lines_t bus_i,
  output bus_ctrl_pkg::bus_lines_t bus_o,
  output bus_ctrl_pkg::bus_lines_t bus_oe_o
);
  typedef enum logic [3:0] {
    S_IFC,
    S_IDLE,
    S_T_WAIT_RDY,
    S_T_SETTLE,
    S_T_WAIT_ACC,
    S_T_WAIT_NACC,
    S_L_RDY,
    S_L_ACC,
    S_L_WAIT_DROP,
    S_PPOLL,
    S_SP_SEQ
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    bus_ctrl_pkg::bus_lines_t s1;
    bus_ctrl_pkg::bus_lines_t s2;
    logic [bus_ctrl_pkg::CNT_W-1:0] cnt;
    logic [7:0] dio;
    logic atn;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic ifc;
    logic ren;
    logic in_charge;
    logic [7:0] rx_byte;
    logic rx_end;
    logic rx_push;
    logic [7:0] pp_stat;
    logic pp_done;
    logic [7:0] sp_stat;
    logic sp_done;
    logic [2:0] sp_step;
    logic sp_active;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic buf_ready;
  bus_ctrl_pkg::word_t buf_word;
  logic buf_valid;
  logic rx_in_ready;
  logic buf_pop;
  logic [8:0] rx_pack;
  logic [8:0] rx_unpack;
  logic a_nrfd;
  logic a_ndac;
  logic a_dav;
  logic a_srq;
  logic a_eoi;

  word_buf #(.WIDTH(9)) rx_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_data_i(rx_pack),
    .in_valid_i(st_ff.rx_push),
    .in_ready_o(rx_in_ready),
    .out_data_o(rx_unpack),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  word_buf #(.WIDTH($bits(bus_ctrl_pkg::word_t))) tx_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_data_i(tx_word_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(buf_ready),
    .out_data_o(buf_word),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  assign rx_pack = {st_ff.rx_end, st_ff.rx_byte};
  assign tx_ready_o = buf_ready;
  assign rx_byte_o = rx_unpack[7:0];
  assign rx_end_o = rx_unpack[8];

  // Synchronized, active-high views of the lines
  assign a_nrfd = ~st_ff.s2.nrfd_n;
  assign a_ndac = ~st_ff.s2.ndac_n;
  assign a_dav = ~st_ff.s2.dav_n;
  assign a_srq = ~st_ff.s2.srq_n;
  assign a_eoi = ~st_ff.s2.eoi_n;

  always_comb begin
    nxt_st = st_ff;
    buf_pop = 1'b0;
    nxt_st.s1 = bus_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.rx_push = 1'b0;
    nxt_st.pp_done = 1'b0;
    nxt_st.sp_done = 1'b0;
    nxt_st.ren = remote_en_i && st_ff.in_charge;
    unique case (st_ff.fsm)
      S_IFC: begin
        nxt_st.ifc = 1'b1;
        nxt_st.in_charge = 1'b0;
        nxt_st.atn = 1'b0;
        nxt_st.dav = 1'b0;
        nxt_st.eoi = 1'b0;
        if (st_ff.cnt >= bus_ctrl_pkg::CNT_W'(IFC_CYCLES - 1)) begin
          nxt_st.ifc = 1'b0;
          nxt_st.in_charge = 1'b1;
          nxt_st.fsm = S_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      S_IDLE: begin
        nxt_st.cnt = '0;
        nxt_st.nrfd = 1'b0;
        nxt_st.ndac = 1'b0;
        nxt_st.eoi = 1'b0;
        if (ifc_req_i) begin
          nxt_st.fsm = S_IFC;
        end else if (ppoll_req_i) begin
          nxt_st.atn = 1'b1;
          nxt_st.eoi = 1'b1;
          nxt_st.fsm = S_PPOLL;
        end else if (auto_spoll_i && a_srq && !st_ff.sp_active) begin
          nxt_st.sp_active = 1'b1;
          nxt_st.sp_step = '0;
          nxt_st.fsm = S_SP_SEQ;
        end else if (buf_valid) begin
          nxt_st.dio = buf_word.byte_val;
          nxt_st.atn = buf_word.op == bus_ctrl_pkg::OP_CMD;
          nxt_st.eoi = buf_word.op == bus_ctrl_pkg::OP_DATA_END;
          buf_pop = 1'b1;
          nxt_st.fsm = S_T_WAIT_RDY;
        end else if (listen_i) begin
          nxt_st.atn = 1'b0;
          nxt_st.ndac = 1'b1;
          nxt_st.fsm = S_L_RDY;
        end
      end
      S_T_WAIT_RDY: begin
        if (!a_nrfd && a_ndac) begin
          nxt_st.fsm = S_T_SETTLE;
        end
      end
      S_T_SETTLE: begin
        if (st_ff.cnt >= bus_ctrl_pkg::CNT_W'(bus_ctrl_pkg::SETTLE_CYC - 1)) begin
          nxt_st.cnt = '0;
          nxt_st.dav = 1'b1;
          nxt_st.fsm = S_T_WAIT_ACC;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      S_T_WAIT_ACC: begin
        if (!a_ndac) begin
          nxt_st.dav = 1'b0;
          nxt_st.fsm = S_T_WAIT_NACC;
        end
      end
      S_T_WAIT_NACC: begin
        if (a_ndac) begin
          nxt_st.eoi = 1'b0;
          if (st_ff.sp_active) begin
            nxt_st.fsm = S_SP_SEQ;
          end else begin
            nxt_st.fsm = S_IDLE;
          end
        end
      end
      S_L_RDY: begin
        nxt_st.nrfd = !rx_in_ready;
        if (rx_in_ready && a_dav) begin
          nxt_st.nrfd = 1'b1;
          nxt_st.rx_byte = ~st_ff.s2.dio_n;
          nxt_st.rx_end = a_eoi;
          nxt_st.rx_push = 1'b1;
          nxt_st.fsm = S_L_ACC;
        end else if (!listen_i && !st_ff.sp_active) begin
          nxt_st.nrfd = 1'b0;
          nxt_st.ndac = 1'b0;
          nxt_st.fsm = S_IDLE;
        end
      end
      S_L_ACC: begin
        nxt_st.ndac = 1'b0;
        nxt_st.fsm = S_L_WAIT_DROP;
        if (st_ff.sp_active) begin
          nxt_st.sp_stat = st_ff.rx_byte;
          nxt_st.sp_done = 1'b1;
        end
      end
      S_L_WAIT_DROP: begin
        if (!a_dav) begin
          nxt_st.ndac = 1'b1;
          if (st_ff.sp_active) begin
            nxt_st.atn = 1'b1;
            nxt_st.fsm = S_SP_SEQ;
          end else begin
            nxt_st.fsm = S_L_RDY;
          end
        end
      end
      S_PPOLL: begin
        if (st_ff.cnt >= bus_ctrl_pkg::CNT_W'(bus_ctrl_pkg::PPOLL_CYC - 1)) begin
          nxt_st.pp_stat = ~st_ff.s2.dio_n;
          nxt_st.pp_done = 1'b1;
          nxt_st.atn = 1'b0;
          nxt_st.eoi = 1'b0;
          nxt_st.fsm = S_IDLE;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      S_SP_SEQ: begin
        nxt_st.sp_step = st_ff.sp_step + 3'h1;
        nxt_st.atn = 1'b1;
        nxt_st.eoi = 1'b0;
        nxt_st.ndac = 1'b0;
        nxt_st.nrfd = 1'b0;
        nxt_st.fsm = S_T_WAIT_RDY;
        unique case (st_ff.sp_step)
          3'h0: nxt_st.dio = bus_ctrl_pkg::UNLISTEN;
          3'h1: nxt_st.dio = bus_ctrl_pkg::SPOLL_EN;
          3'h2: nxt_st.dio = bus_ctrl_pkg::MY_LISTEN_BASE | {3'h0, my_addr_i};
          3'h3: nxt_st.dio = bus_ctrl_pkg::TALK_BASE | {3'h0, spoll_addr_i};
          3'h4: begin
            nxt_st.atn = 1'b0;
            nxt_st.ndac = 1'b1;
            nxt_st.fsm = S_L_RDY;
          end
          3'h5: nxt_st.dio = bus_ctrl_pkg::SPOLL_DIS;
          default: begin
            nxt_st.sp_active = 1'b0;
            nxt_st.atn = 1'b0;
            nxt_st.fsm = S_IDLE;
          end
        endcase
      end
      default: nxt_st.fsm = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.s1 <= '1;
      st_ff.s2 <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Active-low open-collector drive: pull low when asserted
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bus_o <= '0;
      bus_oe_o <= '0;
    end else begin
      bus_o <= '0;
      bus_oe_o.dio_n <= (nxt_st.fsm inside {S_T_WAIT_RDY, S_T_SETTLE, S_T_WAIT_ACC, S_T_WAIT_NACC})
        ? nxt_st.dio : 8'h00;
      bus_oe_o.atn_n <= nxt_st.atn;
      bus_oe_o.eoi_n <= nxt_st.eoi;
      bus_oe_o.srq_n <= 1'b0;
      bus_oe_o.ifc_n <= nxt_st.ifc;
      bus_oe_o.ren_n <= nxt_st.ren;
      bus_oe_o.dav_n <= nxt_st.dav;
      bus_oe_o.nrfd_n <= nxt_st.nrfd;
      bus_oe_o.ndac_n <= nxt_st.ndac;
    end
  end

  assign ppoll_status_o = st_ff.pp_stat;
  assign ppoll_done_o = st_ff.pp_done;
  assign spoll_status_o = st_ff.sp_stat;
  assign spoll_done_o = st_ff.sp_done;
  assign srq_pending_o = a_srq;
  assign in_charge_o = st_ff.in_charge;
endmodule : bus_ctrl

// file: bus_ctrl_props.sv
// Checker for bus_ctrl: handshake, clear, poll and remote lines.
// Assumes the bind below; an enable bit high means that line is pulled low.
module bus_ctrl_props (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic auto_spoll_i,
  input wire logic remote_en_i,
  input wire logic srq_pending_o,
  input wire logic in_charge_o,
  input wire bus_ctrl_pkg::bus_lines_t bus_i,
  input wire bus_ctrl_pkg::bus_lines_t bus_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_SETTLE = bus_ctrl_pkg::SETTLE_CYC;
  logic [7:0] last_dio_ff;
  logic [15:0] steady_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Cycles the driven data lines have stood unchanged
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      last_dio_ff <= '0;
      steady_ff <= '0;
    end else begin
      last_dio_ff <= bus_oe_o.dio_n;
      steady_ff <= (last_dio_ff != bus_oe_o.dio_n) ? '0 : steady_ff + {15'h0, ~&steady_ff};
    end
  end
  a_dav_after_ready: assert property ($rose(bus_oe_o.dav_n) |-> $past(bus_i.nrfd_n, 2))
    else $error("data valid raised while not ready");
  a_settle_first: assert property ($rose(bus_oe_o.dav_n) |-> steady_ff >= MIN_SETTLE)
    else $error("data valid before settling");
  a_byte_steady: assert property (bus_oe_o.dav_n && $past(bus_oe_o.dav_n) |->
    $stable({bus_oe_o.dio_n, bus_oe_o.atn_n, bus_oe_o.eoi_n})) else $error("byte changed under data valid");
  a_dav_held: assert property (bus_oe_o.dav_n && !bus_i.ndac_n |=> bus_oe_o.dav_n)
    else $error("data valid dropped before accept");
  a_dav_drop: assert property (bus_oe_o.dav_n && bus_i.ndac_n |-> ##[1:8] !bus_oe_o.dav_n)
    else $error("data valid not dropped after accept");
  a_clear_then_charge: assert property ($fell(bus_oe_o.ifc_n) |-> ##[0:4] in_charge_o)
    else $error("not in charge after clear");
  a_clear_not_charged: assert property (bus_oe_o.ifc_n && $past(bus_oe_o.ifc_n) |-> !in_charge_o)
    else $error("in charge during clear");
  a_poll_no_handshake: assert property (bus_oe_o.atn_n && bus_oe_o.eoi_n |-> !bus_oe_o.dav_n)
    else $error("handshake during parallel poll");
  a_remote_follows: assert property ((remote_en_i && in_charge_o) [*3] |-> bus_oe_o.ren_n)
    else $error("remote line not asserted");
  a_srq_polled: assert property ($rose(srq_pending_o) && auto_spoll_i |-> ##[1:1000]
    (bus_oe_o.atn_n && bus_oe_o.dio_n == bus_ctrl_pkg::SPOLL_EN)) else $error("service request not polled");
endmodule : bus_ctrl_props

bind bus_ctrl bus_ctrl_props props (.clock_i, .reset_i, .auto_spoll_i, .remote_en_i,
  .srq_pending_o, .in_charge_o, .bus_i, .bus_oe_o);

// file: bus_node.sv
// Behavioural node: acceptor, one-byte talker, service requester, poll responder.
// Assumes it sees the controller's enables; released lines float high.
module bus_node (
  input wire logic clock_i,
  input wire logic [7:0] stall_i,
  input wire logic srq_req_i,
  input wire logic [2:0] pp_bit_i,
  input wire logic [7:0] status_i,
  input wire logic [4:0] talk_addr_i,
  input wire bus_ctrl_pkg::bus_lines_t oe_i,
  output bus_ctrl_pkg::bus_lines_t bus_o,
  output logic [9:0] got_o,
  output logic got_v_o,
  output logic remote_o
);
  timeunit 1ns;
  timeprecision 100ps;
  bus_ctrl_pkg::bus_lines_t pull = '0;
  bus_ctrl_pkg::bus_lines_t p;
  logic talk = 1'b0;
  logic srq = 1'b0;
  logic remote = 1'b0;
  int acc_n = 0;
  int rdy_n = 0;
  // Wired lines: low if any party pulls
  assign bus_o = bus_ctrl_pkg::bus_lines_t'(~(oe_i | pull));
  always @(posedge clock_i) begin
    p = pull;
    got_v_o <= 1'b0;
    srq = srq | srq_req_i;
    if (!oe_i.ren_n) remote = 1'b0;
    p.dio_n = '0;
    p.eoi_n = 1'b0;
    if (talk && !oe_i.atn_n) begin
      p.nrfd_n = 1'b0;
      p.ndac_n = 1'b0;
      p.dio_n = status_i;
      p.eoi_n = 1'b1;
      if (!pull.dav_n) begin
        p.dav_n = (pull.dio_n == status_i) && !oe_i.nrfd_n;
      end else if (!oe_i.ndac_n) begin
        p.dav_n = 1'b0;
        talk = 1'b0;
        srq = 1'b0;
      end
    end else if (oe_i.dav_n) begin
      p.nrfd_n = 1'b1;
      rdy_n = 0;
      if (pull.ndac_n && acc_n >= stall_i) begin
        p.ndac_n = 1'b0;
        got_o <= {oe_i.atn_n, oe_i.eoi_n, oe_i.dio_n};
        got_v_o <= 1'b1;
        if (oe_i.atn_n && oe_i.ren_n && oe_i.dio_n == (8'h20 | {3'h0, talk_addr_i})) remote = 1'b1;
        if (oe_i.atn_n && oe_i.dio_n[7:5] == 3'b010) talk = oe_i.dio_n[4:0] == talk_addr_i;
      end else acc_n++;
    end else begin
      p.ndac_n = 1'b1;
      p.nrfd_n = rdy_n < stall_i;
      acc_n = 0;
      if (p.nrfd_n) rdy_n++;
    end
    if (oe_i.atn_n && oe_i.eoi_n) p.dio_n[pp_bit_i] = 1'b1;
    p.srq_n = srq;
    pull <= p;
    remote_o <= remote;
  end
endmodule : bus_node

// file: tb_top.sv
// Self-checking bench for bus_ctrl with one behavioural node on the bus.
// Assumes bus_node resolves the wired lines and bus_ctrl_props is bound.
`define CHECK(name, exp, got) \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected %s expected %h seen %h", name, exp, got); \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    bus_ctrl_pkg::word_t w;
    logic [9:0] got;
  } row_t;
  row_t rows [5] = '{'{'{bus_ctrl_pkg::OP_CMD, 8'h3F}, 10'h23F}, '{'{bus_ctrl_pkg::OP_DATA, 8'hA5}, 10'h0A5},
    '{'{bus_ctrl_pkg::OP_DATA, 8'h01}, 10'h001}, '{'{bus_ctrl_pkg::OP_DATA_END, 8'h80}, 10'h180},
    '{'{bus_ctrl_pkg::OP_CMD, 8'h27}, 10'h227}};
  logic [9:0] spoll_cmds [5] = '{{2'b10, bus_ctrl_pkg::UNLISTEN}, {2'b10, bus_ctrl_pkg::SPOLL_EN},
    {2'b10, bus_ctrl_pkg::MY_LISTEN_BASE}, {2'b10, bus_ctrl_pkg::TALK_BASE | 8'h07}, {2'b10, bus_ctrl_pkg::SPOLL_DIS}};
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  bus_ctrl_pkg::word_t tx_word = '0;
  logic tx_valid = 1'b0, rx_ready = 1'b0, listen = 1'b0, ppoll_req = 1'b0, auto_spoll = 1'b0;
  logic ifc_req = 1'b0, remote_en = 1'b0, srq_req = 1'b0, saw_full = 1'b0;
  logic [7:0] stall = 8'h1E, status = 8'h00, rx_byte, ppoll_status, spoll_status;
  logic [2:0] pp_bit = 3'h0;
  logic tx_ready, rx_end, rx_valid, ppoll_done, spoll_done, srq_pending, in_charge, got_v, remote;
  logic [9:0] got, g;
  bus_ctrl_pkg::bus_lines_t bus_w, bus_oe;
  logic [9:0] got_q [$];
  int n_mismatch = 0;
  int comparisons = 0;
  bus_ctrl #(.IFC_CYCLES(20)) uut (.clock_i(clock_i), .reset_i(reset_i), .tx_word_i(tx_word),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_byte_o(rx_byte), .rx_end_o(rx_end),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .listen_i(listen), .ppoll_req_i(ppoll_req),
    .ppoll_status_o(ppoll_status), .ppoll_done_o(ppoll_done), .auto_spoll_i(auto_spoll),
    .my_addr_i(5'h00), .spoll_addr_i(5'h07), .spoll_status_o(spoll_status), .spoll_done_o(spoll_done),
    .srq_pending_o(srq_pending), .ifc_req_i(ifc_req), .remote_en_i(remote_en), .in_charge_o(in_charge),
    .bus_i(bus_w), .bus_o(), .bus_oe_o(bus_oe));
  bus_node node (.clock_i(clock_i), .stall_i(stall), .srq_req_i(srq_req), .pp_bit_i(pp_bit),
    .status_i(status), .talk_addr_i(5'h07), .oe_i(bus_oe), .bus_o(bus_w), .got_o(got), .got_v_o(got_v),
    .remote_o(remote));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (got_v === 1'b1) got_q.push_back(got);
  end
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic clear_check;
    repeat (3) @(negedge clock_i);
    `CHECK("clear line", 1'b0, bus_w.ifc_n)
    `CHECK("charge in clear", 1'b0, in_charge)
    repeat (30) @(negedge clock_i);
    `CHECK("charge after clear", 1'b1, in_charge)
  endtask : clear_check
  task automatic send(input bus_ctrl_pkg::word_t w);
    tx_word = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge clock_i);
    end
    @(negedge clock_i);
  endtask : send
  initial begin
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    clear_check();
    remote_en = 1'b1;
    repeat (4) @(negedge clock_i);
    `CHECK("remote line", 1'b0, bus_w.ren_n)
    foreach (rows[i]) send(rows[i].w);
    tx_valid = 1'b0;
    while (got_q.size() < $size(rows)) @(negedge clock_i);
    `CHECK("buffer refused", 1'b1, saw_full)
    foreach (rows[i]) begin
      g = got_q.pop_front();
      `CHECK("accepted byte", rows[i].got, g)
    end
    `CHECK("node remote", 1'b1, remote)
    for (int b = 0; b < 8; b++) begin
      pp_bit = b[2:0];
      ppoll_req = 1'b1;
      while (ppoll_done !== 1'b1) @(negedge clock_i);
      ppoll_req = 1'b0;
      `CHECK("poll status", 8'h01 << b, ppoll_status)
      @(negedge clock_i);
    end
    stall = 8'h02;
    status = 8'h41;
    auto_spoll = 1'b1;
    srq_req = 1'b1;
    @(negedge clock_i);
    srq_req = 1'b0;
    repeat (2) @(negedge clock_i);
    `CHECK("service pending", 1'b1, srq_pending)
    while (spoll_done !== 1'b1) @(negedge clock_i);
    `CHECK("poll byte", 8'h41, spoll_status)
    while (got_q.size() < 5) @(negedge clock_i);
    auto_spoll = 1'b0;
    `CHECK("service line", 1'b1, bus_w.srq_n)
    `CHECK("service pending", 1'b0, srq_pending)
    foreach (spoll_cmds[i]) begin
      g = got_q.pop_front();
      `CHECK("poll command", spoll_cmds[i], g)
    end
    `CHECK("poll byte kept", 10'h341, {rx_valid, rx_end, rx_byte})
    rx_ready = 1'b1;
    @(negedge clock_i);
    rx_ready = 1'b0;
    listen = 1'b1;
    status = 8'h5A;
    send('{bus_ctrl_pkg::OP_CMD, bus_ctrl_pkg::TALK_BASE | 8'h07});
    send('{bus_ctrl_pkg::OP_CMD, bus_ctrl_pkg::MY_LISTEN_BASE});
    tx_valid = 1'b0;
    while (rx_valid !== 1'b1) @(negedge clock_i);
    repeat (20) @(negedge clock_i);
    `CHECK("received byte", 10'h35A, {rx_valid, rx_end, rx_byte})
    rx_ready = 1'b1;
    @(negedge clock_i);
    rx_ready = 1'b0;
    `CHECK("buffer drained", 1'b0, rx_valid)
    listen = 1'b0;
    ifc_req = 1'b1;
    while (bus_oe.ifc_n !== 1'b1) @(negedge clock_i);
    ifc_req = 1'b0;
    clear_check();
    `CHECK("node remote", 1'b0, remote)
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
